//--- src/pbgpio_pkg.sv
// Package for the shared port with upper address lines.
// Assumes a plain register port with byte-wide data.
`default_nettype none
package pbgpio_pkg;
  localparam int PB_W = 8;
  localparam int PB_AW = 2;
  localparam logic [1:0] OFS_PORT_DIRECTION = 2'h0;
  localparam logic [1:0] OFS_PORT_OUTPUT_DATA = 2'h1;
  localparam logic [1:0] OFS_PORT_PIN_STATE = 2'h2;
  localparam logic [1:0] OFS_PORT_PULLUP_CONTROL = 2'h3;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PORT_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_PULLUP_CONTROL = 8'h00;
  localparam logic [2:0] MODE_ADDR_LO = 3'h4;
  localparam logic [2:0] MODE_ADDR_HI = 3'h6;
  localparam logic [2:0] MODE_SINGLE_CHIP = 3'h7;
  typedef logic [PB_W-1:0] pbgpio_byte_t;

  // Pin n carries address bit n+8 when field value >= n+1
  function automatic pbgpio_byte_t pbgpio_addr_sel(input logic [3:0] ae);
    pbgpio_byte_t s;
    s = '0;
    for (int n = 0; n < PB_W; n++) begin
      s[n] = ({1'b0, ae} >= 5'(n + 1));
    end
    return s;
  endfunction
endpackage
`default_nettype wire

//--- src/pbgpio_if.sv
// Bundle carrying the register file state to the pin mux.
// Assumes one clock domain, both ends in the same top.
`default_nettype none
interface pbgpio_regs_if;
  import pbgpio_pkg::*;
  pbgpio_byte_t dir;
  pbgpio_byte_t odr;
  pbgpio_byte_t pcr;
  modport regs (output dir, output odr, output pcr);
  modport mux (input dir, input odr, input pcr);
endinterface
`default_nettype wire

//--- src/pbgpio_mux.sv
// Pin function mux: address vs port output, and pull-up gating.
// Assumes mode and field inputs are synchronous and stable.
`default_nettype none
module pbgpio_mux
  import pbgpio_pkg::*;
(
  pbgpio_regs_if.mux regs,
  input wire logic [2:0] mode,
  input wire logic [3:0] ae,
  input wire logic [7:0] addr_hi,
  input wire logic pu_force_off,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pu_en,
  output logic [7:0] addr_sel
);
  logic addr_mode;
  assign addr_mode = (mode >= MODE_ADDR_LO) && (mode <= MODE_ADDR_HI);
  assign addr_sel = addr_mode ? pbgpio_addr_sel(ae) : '0;
  // Address wins over direction; mode 7 is pure port
  assign pin_oe = addr_sel | regs.dir;
  assign pin_o = (addr_sel & addr_hi) | (~addr_sel & regs.odr);
  // Pull-up only on a true port input
  assign pu_en = pu_force_off ? '0
               : (~regs.dir & ~addr_sel & regs.pcr);
endmodule // pbgpio_mux
`default_nettype wire

//--- src/pbgpio_top.sv
// Top of the shared port: registers, read path and pin mux.
// Assumes a one-cycle strobe register port and synchronous pin inputs;
// the address-enable field comes from a register outside this block.
`default_nettype none
module pbgpio_top
  import pbgpio_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [2:0] MODE,
  input wire logic [3:0] ADDRESS_ENABLE_FIELD,
  input wire logic [7:0] UPPER_ADDRESS_LINES,
  input wire logic STANDBY,
  input wire logic [7:0] PORT_PINS_I,
  output logic [7:0] PORT_PINS_O,
  output logic [7:0] PORT_PINS_OE,
  output logic [7:0] PULLUP_EN,
  output logic [7:0] ADDR_DRIVE
);
  pbgpio_regs_if regs_if ();
  pbgpio_byte_t dir_q, odr_q, pcr_q, rdata_q, pin_state;

  assign regs_if.dir = dir_q;
  assign regs_if.odr = odr_q;
  assign regs_if.pcr = pcr_q;

  // Write-only: software must keep its own shadow copy
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dir_q <= RST_PORT_DIRECTION;
    end else if (CE && WR && ADDR == OFS_PORT_DIRECTION) begin
      dir_q <= WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      odr_q <= RST_PORT_OUTPUT_DATA;
    end else if (CE && WR && ADDR == OFS_PORT_OUTPUT_DATA) begin
      odr_q <= WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pcr_q <= RST_PORT_PULLUP_CONTROL;
    end else if (CE && WR && ADDR == OFS_PORT_PULLUP_CONTROL) begin
      pcr_q <= WDATA;
    end
  end

  assign pin_state = (dir_q & odr_q) | (~dir_q & PORT_PINS_I);

  // Direction reads as zero; writes to pin state are dropped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      if (RD) begin
        unique case (ADDR)
          OFS_PORT_DIRECTION: rdata_q <= 8'h00;
          OFS_PORT_OUTPUT_DATA: rdata_q <= odr_q;
          OFS_PORT_PIN_STATE: rdata_q <= pin_state;
          OFS_PORT_PULLUP_CONTROL: rdata_q <= pcr_q;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign RDATA = rdata_q;

  // Field is an input: its register sits elsewhere
  pbgpio_mux u_mux (
    .regs(regs_if.mux),
    .mode(MODE),
    .ae(ADDRESS_ENABLE_FIELD),
    .addr_hi(UPPER_ADDRESS_LINES),
    .pu_force_off(RST || STANDBY),
    .pin_o(PORT_PINS_O),
    .pin_oe(PORT_PINS_OE),
    .pu_en(PULLUP_EN),
    .addr_sel(ADDR_DRIVE)
  );

  logic am;
  assign am = MODE >= MODE_ADDR_LO && MODE <= MODE_ADDR_HI;

  // Pull-up gating as a whole
  a_pullup_gate: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN == (STANDBY ? 8'h00 : (~PORT_PINS_OE & pcr_q)))
    else $error("pull-up mismatch");
  a_out_no_pull: assert property (
    @(posedge CLK) disable iff (RST)
    (PULLUP_EN & PORT_PINS_OE) == 8'h00)
    else $error("pull-up on driven pin");
  a_standby_off: assert property (
    @(posedge CLK) disable iff (RST)
    STANDBY |-> PULLUP_EN == 8'h00)
    else $error("pull-up in standby");
  // No disable here: the force must hold while reset is asserted
  a_reset_pu_off: assert property (
    @(posedge CLK)
    RST |-> PULLUP_EN == 8'h00)
    else $error("pull-up during reset");

  // Address lines against the field, pin by pin
  a_addr_pin7: assert property (
    @(posedge CLK) disable iff (RST)
    (am && ADDRESS_ENABLE_FIELD[3]) |-> PORT_PINS_OE[7] &&
    PORT_PINS_O[7] == UPPER_ADDRESS_LINES[7])
    else $error("pin 7 not on address");
  a_addr_pin0: assert property (
    @(posedge CLK) disable iff (RST)
    (am && ADDRESS_ENABLE_FIELD == 4'h0) |-> !ADDR_DRIVE[0])
    else $error("pin 0 wrongly on address");
  a_addr_on_p0: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h1
    |-> PORT_PINS_OE[0] && PORT_PINS_O[0] == UPPER_ADDRESS_LINES[0])
    else $error("pin 0 not on address");
  a_addr_on_p1: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h2
    |-> PORT_PINS_OE[1] && PORT_PINS_O[1] == UPPER_ADDRESS_LINES[1])
    else $error("pin 1 not on address");
  a_addr_on_p2: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h3
    |-> PORT_PINS_OE[2] && PORT_PINS_O[2] == UPPER_ADDRESS_LINES[2])
    else $error("pin 2 not on address");
  a_addr_on_p3: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h4
    |-> PORT_PINS_OE[3] && PORT_PINS_O[3] == UPPER_ADDRESS_LINES[3])
    else $error("pin 3 not on address");
  a_addr_on_p4: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h5
    |-> PORT_PINS_OE[4] && PORT_PINS_O[4] == UPPER_ADDRESS_LINES[4])
    else $error("pin 4 not on address");
  a_addr_on_p5: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h6
    |-> PORT_PINS_OE[5] && PORT_PINS_O[5] == UPPER_ADDRESS_LINES[5])
    else $error("pin 5 not on address");
  a_addr_on_p6: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD >= 4'h7
    |-> PORT_PINS_OE[6] && PORT_PINS_O[6] == UPPER_ADDRESS_LINES[6])
    else $error("pin 6 not on address");
  a_addr_off_p1: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h2
    |-> !ADDR_DRIVE[1] && PORT_PINS_OE[1] == dir_q[1])
    else $error("pin 1 wrongly on address");
  a_addr_off_p2: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h3
    |-> !ADDR_DRIVE[2] && PORT_PINS_OE[2] == dir_q[2])
    else $error("pin 2 wrongly on address");
  a_addr_off_p3: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h4
    |-> !ADDR_DRIVE[3] && PORT_PINS_OE[3] == dir_q[3])
    else $error("pin 3 wrongly on address");
  a_addr_off_p4: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h5
    |-> !ADDR_DRIVE[4] && PORT_PINS_OE[4] == dir_q[4])
    else $error("pin 4 wrongly on address");
  a_addr_off_p5: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h6
    |-> !ADDR_DRIVE[5] && PORT_PINS_OE[5] == dir_q[5])
    else $error("pin 5 wrongly on address");
  a_addr_off_p6: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h7
    |-> !ADDR_DRIVE[6] && PORT_PINS_OE[6] == dir_q[6])
    else $error("pin 6 wrongly on address");
  a_addr_off_p7: assert property (
    @(posedge CLK) disable iff (RST) am && ADDRESS_ENABLE_FIELD < 4'h8
    |-> !ADDR_DRIVE[7] && PORT_PINS_OE[7] == dir_q[7])
    else $error("pin 7 wrongly on address");

  // Port behaviour outside the address modes, and port data on non-address pins in every mode
  a_mode7_port: assert property (
    @(posedge CLK) disable iff (RST)
    MODE == MODE_SINGLE_CHIP |-> PORT_PINS_OE == dir_q &&
    PORT_PINS_O == odr_q)
    else $error("mode 7 not pure port");
  a_no_addr_port: assert property (
    @(posedge CLK) disable iff (RST)
    !am |-> ADDR_DRIVE == 8'h00 && PORT_PINS_OE == dir_q)
    else $error("address outside address modes");
  a_port_value: assert property (
    @(posedge CLK) disable iff (RST)
    (PORT_PINS_O & ~ADDR_DRIVE) == (odr_q & ~ADDR_DRIVE))
    else $error("port pin not driven from data");

  // Register writes and holds
  a_dir_write: assert property (
    @(posedge CLK) disable iff (RST)
    CE && WR && ADDR == OFS_PORT_DIRECTION |=> dir_q == $past(WDATA))
    else $error("direction write lost");
  a_odr_write: assert property (
    @(posedge CLK) disable iff (RST)
    CE && WR && ADDR == OFS_PORT_OUTPUT_DATA |=> odr_q == $past(WDATA))
    else $error("data write lost");
  a_pcr_write: assert property (
    @(posedge CLK) disable iff (RST)
    CE && WR && ADDR == OFS_PORT_PULLUP_CONTROL |=> pcr_q == $past(WDATA))
    else $error("control write lost");
  a_hold_dir: assert property (
    @(posedge CLK) disable iff (RST)
    !(CE && WR && ADDR == OFS_PORT_DIRECTION) |=> dir_q == $past(dir_q))
    else $error("direction changed unasked");
  a_hold_odr: assert property (
    @(posedge CLK) disable iff (RST)
    !(CE && WR && ADDR == OFS_PORT_OUTPUT_DATA) |=> odr_q == $past(odr_q))
    else $error("data changed unasked");
  a_hold_pcr: assert property (
    @(posedge CLK) disable iff (RST)
    !(CE && WR && ADDR == OFS_PORT_PULLUP_CONTROL) |=>
    pcr_q == $past(pcr_q))
    else $error("control changed unasked");
  a_state_ro: assert property (
    @(posedge CLK) disable iff (RST)
    CE && WR && ADDR == OFS_PORT_PIN_STATE |=>
    dir_q == $past(dir_q) && odr_q == $past(odr_q) &&
    pcr_q == $past(pcr_q))
    else $error("pin state write had effect");

  // Clock enable low freezes every register
  a_ce_hold_dir: assert property (
    @(posedge CLK) disable iff (RST)
    !CE |=> dir_q == $past(dir_q))
    else $error("direction moved while frozen");
  a_ce_hold_odr: assert property (
    @(posedge CLK) disable iff (RST)
    !CE |=> odr_q == $past(odr_q))
    else $error("data moved while frozen");
  a_ce_hold_pcr: assert property (
    @(posedge CLK) disable iff (RST)
    !CE |=> pcr_q == $past(pcr_q))
    else $error("control moved while frozen");
  a_ce_hold_rd: assert property (
    @(posedge CLK) disable iff (RST)
    !CE |=> RDATA == $past(RDATA))
    else $error("read data moved while frozen");

  // Read path
  a_read_dir: assert property (
    @(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_PORT_DIRECTION |=> RDATA == 8'h00)
    else $error("direction read not zero");
  a_read_odr: assert property (
    @(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_PORT_OUTPUT_DATA |=> RDATA == $past(odr_q))
    else $error("data read wrong");
  a_read_pcr: assert property (
    @(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_PORT_PULLUP_CONTROL |=> RDATA == $past(pcr_q))
    else $error("control read wrong");
  a_rdata_idle: assert property (
    @(posedge CLK) disable iff (RST)
    CE && !RD |=> RDATA == 8'h00)
    else $error("read data stands too long");
  a_read_state: assert property (
    @(posedge CLK) disable iff (RST)
    CE && RD && ADDR == OFS_PORT_PIN_STATE |=>
    RDATA == (($past(dir_q) & $past(odr_q)) |
    (~$past(dir_q) & $past(PORT_PINS_I))))
    else $error("pin state read wrong");
  a_read_p0: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[0] == ($past(dir_q[0]) ? $past(odr_q[0])
                     : $past(PORT_PINS_I[0])))
    else $error("pin 0 state read wrong");
  a_read_p1: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[1] == ($past(dir_q[1]) ? $past(odr_q[1])
                     : $past(PORT_PINS_I[1])))
    else $error("pin 1 state read wrong");
  a_read_p2: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[2] == ($past(dir_q[2]) ? $past(odr_q[2])
                     : $past(PORT_PINS_I[2])))
    else $error("pin 2 state read wrong");
  a_read_p3: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[3] == ($past(dir_q[3]) ? $past(odr_q[3])
                     : $past(PORT_PINS_I[3])))
    else $error("pin 3 state read wrong");
  a_read_p4: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[4] == ($past(dir_q[4]) ? $past(odr_q[4])
                     : $past(PORT_PINS_I[4])))
    else $error("pin 4 state read wrong");
  a_read_p5: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[5] == ($past(dir_q[5]) ? $past(odr_q[5])
                     : $past(PORT_PINS_I[5])))
    else $error("pin 5 state read wrong");
  a_read_p6: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[6] == ($past(dir_q[6]) ? $past(odr_q[6])
                     : $past(PORT_PINS_I[6])))
    else $error("pin 6 state read wrong");
  a_read_p7: assert property (
    @(posedge CLK) disable iff (RST) CE && RD && ADDR == OFS_PORT_PIN_STATE
    |=> RDATA[7] == ($past(dir_q[7]) ? $past(odr_q[7])
                     : $past(PORT_PINS_I[7])))
    else $error("pin 7 state read wrong");

  // Pull-up truth table, pin by pin
  a_pu_p0: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[0] == (!STANDBY && !dir_q[0] && !ADDR_DRIVE[0] && pcr_q[0]))
    else $error("pin 0 pull-up wrong");
  a_pu_p1: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[1] == (!STANDBY && !dir_q[1] && !ADDR_DRIVE[1] && pcr_q[1]))
    else $error("pin 1 pull-up wrong");
  a_pu_p2: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[2] == (!STANDBY && !dir_q[2] && !ADDR_DRIVE[2] && pcr_q[2]))
    else $error("pin 2 pull-up wrong");
  a_pu_p3: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[3] == (!STANDBY && !dir_q[3] && !ADDR_DRIVE[3] && pcr_q[3]))
    else $error("pin 3 pull-up wrong");
  a_pu_p4: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[4] == (!STANDBY && !dir_q[4] && !ADDR_DRIVE[4] && pcr_q[4]))
    else $error("pin 4 pull-up wrong");
  a_pu_p5: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[5] == (!STANDBY && !dir_q[5] && !ADDR_DRIVE[5] && pcr_q[5]))
    else $error("pin 5 pull-up wrong");
  a_pu_p6: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[6] == (!STANDBY && !dir_q[6] && !ADDR_DRIVE[6] && pcr_q[6]))
    else $error("pin 6 pull-up wrong");
  a_pu_p7: assert property (
    @(posedge CLK) disable iff (RST)
    PULLUP_EN[7] == (!STANDBY && !dir_q[7] && !ADDR_DRIVE[7] && pcr_q[7]))
    else $error("pin 7 pull-up wrong");


  c_addr_mode: cover property (@(posedge CLK) am && ADDR_DRIVE == 8'hff);
  c_pull_on: cover property (@(posedge CLK) PULLUP_EN != 8'h00);
  c_read_pin: cover property (@(posedge CLK) RD && ADDR == OFS_PORT_PIN_STATE);
  c_frozen_wr: cover property (@(posedge CLK) !CE && WR);
  c_standby: cover property (@(posedge CLK) STANDBY && pcr_q != 8'h00);
endmodule // pbgpio_top
`default_nettype wire

//--- sim/pbgpio_pins.sv
// Pad model: design drive, outside driver and pull-up.
// Assumes one clock; the outside drive comes from the bench.
`default_nettype none
module pbgpio_pins (
  input wire logic clk,
  input wire logic [7:0] oe,
  input wire logic [7:0] o,
  input wire logic [7:0] pu,
  input wire logic ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q;
  // A floating pin drifts, so it never shows its old level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl[i] = oe[i] ? o[i] : ext_en ? ext_val[i] :
        pu[i] ? 1'b1 : ~last_q[i];
    end
  end
  always_ff @(posedge clk) last_q <= lvl;
endmodule // pbgpio_pins
`default_nettype wire

//--- sim/pbgpio_tb.sv
// Self-checking bench for the shared port block.
// Assumes the pad model is compiled first.
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench
  import pbgpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, STANDBY = 0, ext_en = 0;
  logic [1:0] ADDR = 0;
  logic [2:0] MODE = 3'h7;
  logic [3:0] AEF = 0;
  logic [7:0] WDATA = 0, UAL = 0, ext_val = 0, sel;
  logic [7:0] RDATA, PIN_I, PIN_O, PIN_OE, PU, ADRV;
  int miscompares = 0, checks_done = 0;
  pbgpio_top i_dut (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MODE(MODE),
    .ADDRESS_ENABLE_FIELD(AEF), .UPPER_ADDRESS_LINES(UAL),
    .STANDBY(STANDBY), .PORT_PINS_I(PIN_I), .PORT_PINS_O(PIN_O),
    .PORT_PINS_OE(PIN_OE), .PULLUP_EN(PU), .ADDR_DRIVE(ADRV));
  pbgpio_pins i_pins (.clk(CLK), .oe(PIN_OE), .o(PIN_O), .pu(PU),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(PIN_I));
  initial forever #10 CLK = ~CLK;
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic cr(input logic [1:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 `CHK(RDATA, e)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge CLK);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    cr(OFS_PORT_OUTPUT_DATA, RST_PORT_OUTPUT_DATA);
    cr(OFS_PORT_PULLUP_CONTROL, RST_PORT_PULLUP_CONTROL);
    cr(OFS_PORT_DIRECTION, 8'h00);
    `CHK(PU, 8'h00)
    $display("test reset done");
    wr(OFS_PORT_DIRECTION, 8'hF0);
    wr(OFS_PORT_OUTPUT_DATA, 8'hA5);
    ext_en <= 1'b1;
    ext_val <= 8'h3C;
    wr(OFS_PORT_PIN_STATE, 8'hFF);
    `CHK(PIN_OE, 8'hF0)
    `CHK(PIN_O & 8'hF0, 8'hA0)
    cr(OFS_PORT_PIN_STATE, 8'hAC);
    cr(OFS_PORT_OUTPUT_DATA, 8'hA5);
    wr(OFS_PORT_PULLUP_CONTROL, 8'hFF);
    ext_en <= 1'b0;
    cr(OFS_PORT_PIN_STATE, 8'hAF);
    `CHK(PU, 8'h0F)
    @(posedge CLK);
    STANDBY <= 1'b1;
    #1 `CHK(PU, 8'h00)
    STANDBY <= 1'b0;
    $display("test port done");
    for (int m = 4; m <= 6; m++) begin
      for (int a = 0; a < 16; a++) begin
        @(posedge CLK);
        MODE <= 3'(m);
        AEF <= 4'(a);
        UAL <= ~8'(a * 37);
        #1 sel = (a >= 8) ? 8'hFF : 8'((16'h0001 << a) - 16'h0001);
        `CHK(ADRV, sel)
        `CHK(PIN_OE, sel | 8'hF0)
        `CHK(PIN_O & PIN_OE, (sel & UAL) | (~sel & 8'hA0))
        `CHK(PU, 8'h0F & ~sel)
        if (a == 2) `CHK(ADRV[1:0], 2'h3)
      end
    end
    CE <= 1'b0;
    wr(OFS_PORT_OUTPUT_DATA, 8'h5A);
    CE <= 1'b1;
    cr(OFS_PORT_OUTPUT_DATA, 8'hA5);
    @(posedge CLK);
    MODE <= 3'h0;
    AEF <= 4'hF;
    #1 `CHK(ADRV, 8'h00)
    `CHK(PIN_OE, 8'hF0)
    @(posedge CLK);
    MODE <= 3'h7;
    RST <= 1'b1;
    #1 `CHK(PU, 8'h00)
    @(posedge CLK);
    RST <= 1'b0;
    cr(OFS_PORT_OUTPUT_DATA, 8'h00);
    `CHK(PIN_OE, 8'h00)
    $display("test address done");
    final_report;
  end
endmodule // testbench
`default_nettype wire
